// >>> rtl/sdl_pkg.sv
// package of constants for the serial channel latch loader
package sdl_pkg;
	localparam int         WORD_BITS   = 12;
	localparam int         ADDR_BITS   = 4;
	localparam int         VALUE_BITS  = 8;
	localparam int         NUM_CHAN    = 12;
	localparam int         ADDR_MSB    = 11;
	localparam int         ADDR_LSB    = 8;
	localparam logic [7:0] MIDSCALE    = 8'h80;
	localparam logic [11:0] WORD_RESET = 12'h000;
	localparam logic [3:0] LAST_ADDR   = 4'hB;
	// idle pin levels: power down, preset, select and clock high, data low
	localparam logic [4:0] PIN_IDLE    = 5'h1B;
endpackage : sdl_pkg

// >>> rtl/sdl_chan_reg.sv
// one channel value register with midscale preset
`timescale 1ns/1ps
module sdl_chan_reg #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_rstn,
	// preset and load
	input  wire logic         i_preset,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_value,
	// stored value
	output logic      [W-1:0] o_value
);
	logic [W-1:0] value_q;
	logic [W-1:0] value_d;

	always_comb
	begin
		value_d = value_q;
		if (i_preset)
			value_d = W'(sdl_pkg::MIDSCALE); // RULE_15
		else if (i_load)
			value_d = i_value; // RULE_06
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
			value_q <= W'(sdl_pkg::MIDSCALE);
		else
			value_q <= value_d;
	end

	assign o_value = value_q;
endmodule : sdl_chan_reg

// >>> rtl/sdl_loader.sv
// serial word loader feeding twelve channel value registers
// ----------------------------------------------------------------------
// Notes on behaviour
// [RULE_01] select high: shift clock ignored, serial register held.
// [RULE_02] select low: each rising shift clock edge shifts in one data bit.
// [RULE_03] host keeps shift clock high when select rises.
// [RULE_04] rising select captures the last twelve shifted bits.
// [RULE_05] rising select enables decoder, loading at most one channel.
// [RULE_06] chosen channel takes the low eight bits; others unchanged.
// [RULE_07] word is four address bits then eight value bits.
// [RULE_08] surplus leading bits are dropped; only the final twelve count.
// [RULE_09] host frames each channel word with its own select low.
// [RULE_10] host lowers select before the first shift clock edge.
// [RULE_11] power down low opens every channel output.
// [RULE_12] bits arrive most significant first, address then value.
// [RULE_13] channel number is address plus one; 1011 is the twelfth.
// [RULE_14] power down keeps every channel register value.
// [RULE_15] preset low loads every channel register with 128.
// [RULE_16] address codes 1100 to 1111 change no channel.
// ----------------------------------------------------------------------
`timescale 1ns/1ps
module sdl_loader #(
	parameter int NUM_CHAN = sdl_pkg::NUM_CHAN,
	parameter int VAL_W    = sdl_pkg::VALUE_BITS
) (
	// clock and reset
	input  wire logic                      i_core_clk,
	input  wire logic                      i_rstn,
	// serial link pins
	input  wire logic                      i_select_low,
	input  wire logic                      i_shift_clk,
	input  wire logic                      i_serial_in_pin,
	// control pins
	input  wire logic                      i_midscale_preset_low,
	input  wire logic                      i_power_down_low,
	// channel outputs: value and output enable (low = driving)
	output logic [NUM_CHAN*VAL_W-1:0]      o_channel_outputs,
	output logic [NUM_CHAN-1:0]            o_channel_oe_n,
	// last captured word
	output logic [sdl_pkg::WORD_BITS-1:0]  o_word
);
	localparam int WB = sdl_pkg::WORD_BITS;

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [4:0] meta_q;
	logic [4:0] sync_q;
	logic       sclk_prev_q;
	logic       sel_prev_q;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
		begin
			meta_q      <= sdl_pkg::PIN_IDLE;
			sync_q      <= sdl_pkg::PIN_IDLE;
			sclk_prev_q <= 1'b1;
			sel_prev_q  <= 1'b1;
		end
		else
		begin
			meta_q      <= {i_power_down_low, i_midscale_preset_low, i_serial_in_pin,
			                i_shift_clk, i_select_low};
			sync_q      <= meta_q;
			sclk_prev_q <= sync_q[1];
			sel_prev_q  <= sync_q[0];
		end
	end

	logic sel_n;
	logic sclk_rise;
	logic sel_rise;
	logic sdata;
	logic preset;
	logic pd;
	assign sel_n     = sync_q[0];
	assign sclk_rise = sync_q[1] & ~sclk_prev_q;
	assign sel_rise  = sel_n & ~sel_prev_q;
	assign sdata     = sync_q[2];
	assign preset    = ~sync_q[3];
	assign pd        = ~sync_q[4];

	// ------------------------------------------------------------------
	// serial register and word capture
	// ------------------------------------------------------------------
	// a twelve bit window naturally drops older leading bits
	logic [WB-1:0] shift_q;
	logic [WB-1:0] shift_d;
	logic [WB-1:0] word_q;
	logic [WB-1:0] word_d;
	logic          load_q;
	logic          load_d;

	always_comb
	begin
		shift_d = shift_q; // RULE_01
		if (!sel_n && sclk_rise)
			shift_d = {shift_q[WB-2:0], sdata}; // RULE_02 RULE_08 RULE_12
		word_d = word_q;
		load_d = 1'b0;
		if (sel_rise)
		begin
			word_d = shift_q; // RULE_04
			load_d = 1'b1; // RULE_05
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
		begin
			shift_q <= sdl_pkg::WORD_RESET;
			word_q  <= sdl_pkg::WORD_RESET;
			load_q  <= 1'b0;
		end
		else
		begin
			shift_q <= shift_d;
			word_q  <= word_d;
			load_q  <= load_d;
		end
	end

	// ------------------------------------------------------------------
	// address decode and channel registers
	// ------------------------------------------------------------------
	logic [3:0]       addr;
	logic [VAL_W-1:0] val;
	assign addr = word_q[sdl_pkg::ADDR_MSB:sdl_pkg::ADDR_LSB]; // RULE_07
	assign val  = word_q[VAL_W-1:0];

	logic [NUM_CHAN*VAL_W-1:0] chan_val;
	genvar g;
	generate
		for (g = 0; g < NUM_CHAN; g++)
		begin : g_chan
			logic hit;
			// channel g answers to address g; unused codes hit nothing
			assign hit = load_q && (addr == 4'(g)); // RULE_05 RULE_13 RULE_16
			sdl_chan_reg #(
				.W       (VAL_W)
			) u_reg (
				.i_core_clk (i_core_clk),
				.i_rstn     (i_rstn),
				.i_preset   (preset),
				.i_load     (hit),
				.i_value    (val),
				.o_value    (chan_val[g*VAL_W +: VAL_W])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// output stage
	// ------------------------------------------------------------------
	logic [NUM_CHAN*VAL_W-1:0] out_q;
	logic [NUM_CHAN-1:0]       oe_n_q;
	logic [NUM_CHAN-1:0]       oe_n_d;

	always_comb
	begin
		oe_n_d = pd ? {NUM_CHAN{1'b1}} : {NUM_CHAN{1'b0}}; // RULE_11
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
		begin
			out_q  <= '0;
			oe_n_q <= '1;
		end
		else
		begin
			out_q  <= chan_val; // RULE_14
			oe_n_q <= oe_n_d;
		end
	end

	assign o_channel_outputs = out_q;
	assign o_channel_oe_n    = oe_n_q;
	assign o_word            = word_q;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence s_sel_rise;
		sel_rise;
	endsequence

	a_shift_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_01
		sel_n |=> $stable(shift_q))
		else $error("serial register moved while select high");

	a_shift_step: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_02
		(!sel_n && sclk_rise) |=> shift_q == {$past(shift_q[WB-2:0]), $past(sdata)})
		else $error("serial register did not shift");

	a_word_capture: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_04
		s_sel_rise |=> word_q == $past(shift_q))
		else $error("word not captured on select rise");

	a_load_once: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_05
		s_sel_rise |=> load_q ##1 !load_q)
		else $error("load strobe not one cycle");

	a_chan_write: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_06
		(load_q && addr <= sdl_pkg::LAST_ADDR && !preset)
		|=> chan_val[$past(addr)*VAL_W +: VAL_W] == $past(val))
		else $error("channel not written");

	a_unused_addr: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_16
		(load_q && addr > sdl_pkg::LAST_ADDR && !preset) |=> $stable(chan_val))
		else $error("unused address changed a channel");

	a_power_down: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_11
		pd |=> o_channel_oe_n == '1)
		else $error("outputs driven during power down");

	a_keep_values: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_14
		(pd && !load_q && !preset) |=> $stable(chan_val))
		else $error("power down changed a channel");

	a_preset_mid: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_15
		preset |=> chan_val == {NUM_CHAN{VAL_W'(sdl_pkg::MIDSCALE)}})
		else $error("preset did not load midscale");
endmodule : sdl_loader

// >>> tb/sdl_host_model.sv
// host model driving the three-wire serial link
`timescale 1ns/1ps
module sdl_host_model (
	// serial link pins
	output logic o_select_low,
	output logic o_shift_clk,
	output logic o_serial_in_pin
);
	// ----------------------------------------
	// framing tasks
	// ----------------------------------------
	initial
	begin
		o_select_low    = 1'b1;
		o_shift_clk     = 1'b1;
		o_serial_in_pin = 1'b0;
	end
	task open_f;
		o_select_low = 1'b0;
		#160;
	endtask : open_f
	// data changes only while the clock is low
	task bit_f(input logic b);
		o_shift_clk     = 1'b0;
		o_serial_in_pin = b;
		#160;
		o_shift_clk = 1'b1;
		#160;
	endtask : bit_f
	// clock already high; released data flips so a stale level never passes
	task close_f;
		o_select_low    = 1'b1;
		o_serial_in_pin = ~o_serial_in_pin;
		#200;
	endtask : close_f
	task idle_clk(input int n);
		repeat (n) bit_f(~o_serial_in_pin);
	endtask : idle_clk
endmodule : sdl_host_model

// >>> tb/testbench.sv
// self-checking bench for the serial channel latch loader
`timescale 1ns/1ps
module testbench;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic        clk      = 1'b0;
	logic        rstn     = 1'b0;
	logic        preset_n = 1'b1;
	logic        pd_n     = 1'b1;
	logic        sel_n;
	logic        sclk;
	logic        serial_in_pin;
	logic [95:0] chan;
	logic [11:0] oe_n;
	logic [11:0] word;
	logic [11:0] last_w   = 12'h000;
	logic [3:0]  nib;
	logic [7:0]  exp_ch [12];
	int          err_total = 0;
	int          checks    = 0;
	always #20 clk = ~clk;
	sdl_host_model i_sdl_host_model (.o_select_low(sel_n), .o_shift_clk(sclk),
		.o_serial_in_pin(serial_in_pin));
	sdl_loader i_sdl_loader (.i_core_clk(clk), .i_rstn(rstn), .i_select_low(sel_n),
		.i_shift_clk(sclk), .i_serial_in_pin(serial_in_pin), .i_midscale_preset_low(preset_n),
		.i_power_down_low(pd_n), .o_channel_outputs(chan), .o_channel_oe_n(oe_n),
		.o_word(word));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	function automatic logic [7:0] next_val(input logic [11:0] w, input int i,
		input logic [7:0] old);
		return (w[11:8] == 4'(i)) ? w[7:0] : old;
	endfunction : next_val
	task check_all;
		chk("word", last_w, word);
		chk("oe_n", pd_n ? 12'h000 : 12'hFFF, oe_n);
		for (int i = 0; i < 12; i++)
			chk("chan", 12'(exp_ch[i]), 12'(chan[i*8+:8]));
	endtask : check_all
	// settle time covers both synchronisers and the output register
	task finish(input logic [11:0] w);
		i_sdl_host_model.close_f();
		last_w = w;
		for (int i = 0; i < 12; i++)
			exp_ch[i] = next_val(w, i, exp_ch[i]);
		cyc(8);
		check_all();
	endtask : finish
	task send(input logic [11:0] w, input int extra);
		i_sdl_host_model.open_f();
		repeat (extra) i_sdl_host_model.bit_f(1'($urandom));
		for (int i = 11; i >= 0; i--)
			i_sdl_host_model.bit_f(w[i]);
		finish(w);
	endtask : send
	task final_report;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		#2000000;
		err_total++;
		final_report();
	end
	initial
	begin
		void'($urandom(7));
		for (int i = 0; i < 12; i++)
			exp_ch[i] = 8'h80;
		cyc(10);
		rstn = 1'b1;
		cyc(6);
		check_all();
		$display("test reset done");
		for (int n = 0; n < 12; n++)
			send({4'(n), 8'($urandom)}, 0);
		for (int n = 12; n < 16; n++)
			send({4'(n), 8'hFF}, 0);
		for (int n = 0; n < 24; n++)
			send(12'($urandom), $urandom_range(4, 0));
		$display("test random done");
		nib = 4'($urandom);
		i_sdl_host_model.idle_clk(5);
		i_sdl_host_model.open_f();
		for (int i = 3; i >= 0; i--)
			i_sdl_host_model.bit_f(nib[i]);
		finish({last_w[7:0], nib});
		$display("test idle clock done");
		pd_n = 1'b0;
		cyc(6);
		check_all();
		pd_n = 1'b1;
		cyc(6);
		check_all();
		$display("test power down done");
		preset_n = 1'b0;
		cyc(6);
		for (int i = 0; i < 12; i++)
			exp_ch[i] = 8'h80;
		check_all();
		preset_n = 1'b1;
		cyc(4);
		send({4'hB, 8'($urandom)}, 0);
		$display("test preset done");
		final_report();
	end
endmodule : testbench
